/* rtl/mmld_decoder.sv */
// Memory map glue decoder and indicator lamp decoder for the board bus
`timescale 1ns/1ns
`default_nettype none

module mmld_decoder
  import mmld_pkg::*;
(
  // Clock and reset
  input  wire logic          i_ref_clk,
  input  wire logic          i_rstn,
  // Board straps
  input  wire logic          i_map_strap_high,
  input  wire logic          i_map_strap_low,
  // Core bus and clock output
  input  wire mmld_bus_t     i_bus,
  input  wire logic          i_core_clock_output,
  // Memory selects
  output var  mmld_mem_sel_t o_mem_sel,
  // Indicator lamps
  output var  logic          o_lamp_one,
  output var  logic          o_lamp_two,
  output var  logic          o_lamp_three,
  output var  logic          o_lamp_four
);

  mmld_map_t                 map_mode;
  mmld_mem_sel_t             next_mem_sel;
  logic                      core_clk_prev;
  logic                      core_tick;
  logic                      data_read;
  logic [LAMP_COUNT-1:0]     lamp_set;
  logic [LAMP_COUNT-1:0]     lamp_clear;
  logic [LAMP_COUNT-1:0]     lamp;

  // Strap pair read as the map code
  assign map_mode = mmld_map_t'({i_map_strap_high, i_map_strap_low});

  // Chip select and output enable for the chosen map
  always_comb begin
    next_mem_sel.ram_ce_n              = 1'b1;
    next_mem_sel.ram_oe_n              = 1'b1;
    next_mem_sel.external_fetch_select = 1'b0;
    case (map_mode)
      MMLD_MAP_SINGLE: begin
        next_mem_sel.ram_ce_n = 1'b1;
        next_mem_sel.ram_oe_n = 1'b1;
      end
      MMLD_MAP_UPPER: begin
        next_mem_sel.ram_ce_n = ~i_bus.addr_high[7];
        next_mem_sel.ram_oe_n = i_bus.rd_n & i_bus.psen_n;
      end
      MMLD_MAP_BOTH: begin
        // Lowest block is kept clear by the core itself
        next_mem_sel.ram_ce_n = 1'b0;
        next_mem_sel.ram_oe_n = i_bus.rd_n & i_bus.psen_n;
      end
      MMLD_MAP_FLASH: begin
        // Core treats its internal RAM as data only here
        next_mem_sel.ram_ce_n              = 1'b0;
        next_mem_sel.ram_oe_n              = i_bus.rd_n & i_bus.psen_n;
        next_mem_sel.external_fetch_select = 1'b1;
      end
      default: begin
        next_mem_sel.ram_ce_n              = RAM_CE_N_RESET;
        next_mem_sel.ram_oe_n              = RAM_OE_N_RESET;
        next_mem_sel.external_fetch_select = EXT_FETCH_RESET;
      end
    endcase
  end

  // Memory select outputs registered so they come from flops
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mem_sel.ram_ce_n              <= RAM_CE_N_RESET;
      o_mem_sel.ram_oe_n              <= RAM_OE_N_RESET;
      o_mem_sel.external_fetch_select <= EXT_FETCH_RESET;
    end else begin
      o_mem_sel <= next_mem_sel;
    end
  end

  // Rising edge of the core clock output; a stopped clock gives no ticks
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      core_clk_prev <= CORE_CLK_RESET;
    end else begin
      core_clk_prev <= i_core_clock_output;
    end
  end

  assign core_tick = i_core_clock_output & ~core_clk_prev;

  // Only the data read strobe qualifies, program fetches never do
  assign data_read = ~i_bus.rd_n;

  // Page decode per lamp on the high byte alone
  always_comb begin
    for (int n = 0; n < LAMP_COUNT; n++) begin
      lamp_set[n]   = data_read &&
                      mmld_page_hit(i_bus.addr_high, mmld_off_page(n) | LAMP_ON_OFFSET);
      lamp_clear[n] = data_read && mmld_page_hit(i_bus.addr_high, mmld_off_page(n));
    end
  end

  // One lamp flop per indicator
  for (genvar g = 0; g < LAMP_COUNT; g++) begin : g_lamp
    mmld_lamp_cell u_cell (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_tick    (core_tick),
      .i_set     (lamp_set[g]),
      .i_clear   (lamp_clear[g]),
      .o_lamp    (lamp[g])
    );
  end

  // Lamp ports taken straight from the cell flops
  assign o_lamp_one   = lamp[0];
  assign o_lamp_two   = lamp[1];
  assign o_lamp_three = lamp[2];
  assign o_lamp_four  = lamp[3];

  // Default map: internal fetch and external RAM selected
  default_map_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_rstn && map_mode == MMLD_MAP_BOTH) |=>
      !o_mem_sel.ram_ce_n && !o_mem_sel.external_fetch_select)
    else $error("default map did not select external RAM with internal fetch");

  // Upper map: select follows A15 of the previous cycle
  upper_map_ce_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (map_mode == MMLD_MAP_UPPER) |=>
      (o_mem_sel.ram_ce_n == !$past(i_bus.addr_high[7])) && !o_mem_sel.external_fetch_select)
    else $error("upper map chip select does not follow the top address bit");

  // External fetch only in the flash map
  ext_fetch_map_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ##1 o_mem_sel.external_fetch_select == ($past(map_mode) == MMLD_MAP_FLASH))
    else $error("external fetch select disagrees with the flash map");

  // Single chip map: everything off
  single_chip_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (map_mode == MMLD_MAP_SINGLE) |=>
      o_mem_sel.ram_ce_n && o_mem_sel.ram_oe_n && !o_mem_sel.external_fetch_select)
    else $error("single chip map left a memory select active");

  // Strap code 01 restricts RAM to the upper half
  strap_encode_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (!i_map_strap_high && i_map_strap_low && !i_bus.addr_high[7]) |=> o_mem_sel.ram_ce_n)
    else $error("strap code 01 selected RAM in the lower half");

  // Output enable on either strobe when RAM is enabled
  ram_oe_strobe_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (map_mode != MMLD_MAP_SINGLE) |=>
      (o_mem_sel.ram_oe_n == ($past(i_bus.rd_n) && $past(i_bus.psen_n))))
    else $error("RAM output enable does not follow the read and fetch strobes");

  // On-page read on a tick lights the lamp; low byte is not looked at
  lamp_set_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (core_tick && !i_bus.rd_n && (i_bus.addr_high & LAMP_DECODE_MASK) == 8'hB8)
      |=> o_lamp_four)
    else $error("read of the on page did not light the fourth lamp");

  // Off-page read anywhere within the page darkens the lamp
  lamp_clear_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (core_tick && !i_bus.rd_n && (i_bus.addr_high & LAMP_DECODE_MASK) == 8'h80)
      |=> !o_lamp_one)
    else $error("read of the off page did not clear the first lamp");

  // No core clock edge means the lamps stay put
  lamp_clock_hold_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !core_tick |=> $stable(lamp))
    else $error("lamps changed while the core clock output was idle");

  // Program fetch without a data read never changes a lamp
  fetch_ignore_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_bus.rd_n && !i_bus.psen_n) |=> $stable(lamp))
    else $error("program fetch changed a lamp");

  // Flash map selects RAM and moves code fetch outside
  flash_map_sel_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_rstn && map_mode == MMLD_MAP_FLASH) |=>
      !o_mem_sel.ram_ce_n && o_mem_sel.external_fetch_select)
    else $error("flash map did not select RAM with external fetch");

  // First lamp lit by a read of its on page
  lamp_one_on_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (core_tick && !i_bus.rd_n && (i_bus.addr_high & LAMP_DECODE_MASK) == 8'h88)
      |=> o_lamp_one)
    else $error("read of the on page did not light the first lamp");

  // Second lamp darkened by a read of its off page
  lamp_two_off_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (core_tick && !i_bus.rd_n && (i_bus.addr_high & LAMP_DECODE_MASK) == 8'h90)
      |=> !o_lamp_two)
    else $error("read of the off page did not clear the second lamp");

  // Third lamp lit by a read of its on page
  lamp_three_on_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (core_tick && !i_bus.rd_n && (i_bus.addr_high & LAMP_DECODE_MASK) == 8'hA8)
      |=> o_lamp_three)
    else $error("read of the on page did not light the third lamp");

  // Fourth lamp darkened by a read of its off page
  lamp_four_off_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (core_tick && !i_bus.rd_n && (i_bus.addr_high & LAMP_DECODE_MASK) == 8'hB0)
      |=> !o_lamp_four)
    else $error("read of the off page did not clear the fourth lamp");

  // Lamps come out of reset dark
  lamp_reset_a : assert property (@(posedge i_ref_clk)
    !i_rstn |=> (lamp == '0) || !i_rstn)
    else $error("lamps were not cleared by reset");

endmodule

`default_nettype wire

/* rtl/mmld_lamp_cell.sv */
// One indicator lamp flop with set and clear on a core clock tick
`timescale 1ns/1ns
`default_nettype none

module mmld_lamp_cell
  import mmld_pkg::*;
(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // Decode
  input  wire logic i_tick,
  input  wire logic i_set,
  input  wire logic i_clear,
  // Lamp
  output var  logic o_lamp
);

  // Lamp holds unless a qualified read hits its page on a core clock edge
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_lamp <= LAMP_RESET;
    end else if (i_tick && i_set) begin
      o_lamp <= 1'b1;
    end else if (i_tick && i_clear) begin
      o_lamp <= 1'b0;
    end
  end

  // Lamp changes only on a tick with a decoded page
  lamp_hold_a : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !(i_tick && (i_set || i_clear)) |=> $stable(o_lamp))
    else $error("lamp changed without a qualified core clock read");

endmodule

`default_nettype wire

/* rtl/mmld_pkg.sv */
// Constants, types and helpers shared by the memory map and lamp decoder
`default_nettype none

package mmld_pkg;

  // Map strap settings, {map_strap_high, map_strap_low}
  typedef enum logic [1:0] {
    MMLD_MAP_SINGLE = 2'b00,  // No external memory at all
    MMLD_MAP_UPPER  = 2'b01,  // External RAM in the upper half only
    MMLD_MAP_FLASH  = 2'b10,  // All program memory external
    MMLD_MAP_BOTH   = 2'b11   // External RAM bottom and top, straps open
  } mmld_map_t;

  // Lamp count and page decode
  localparam int          LAMP_COUNT       = 4;
  localparam logic [7:0]  LAMP_BASE_PAGE   = 8'h80;  // Off page of lamp one
  localparam logic [7:0]  LAMP_ON_OFFSET   = 8'h08;  // On page sits above off page
  localparam logic [7:0]  LAMP_PAGE_STEP   = 8'h10;  // Distance between lamps
  localparam logic [7:0]  LAMP_DECODE_MASK = 8'hF8;  // Address bits 15..11 compared

  // Reset values
  localparam logic        LAMP_RESET       = 1'b0;
  localparam logic        RAM_CE_N_RESET   = 1'b1;
  localparam logic        RAM_OE_N_RESET   = 1'b1;
  localparam logic        EXT_FETCH_RESET  = 1'b0;
  localparam logic        CORE_CLK_RESET   = 1'b0;

  // External bus as seen by the decoder
  typedef struct packed {
    logic [7:0] addr_high;  // Address bits 15..8
    logic       rd_n;       // Data read strobe
    logic       psen_n;     // Program fetch strobe
  } mmld_bus_t;

  // Memory selects driven to the board
  typedef struct packed {
    logic ram_ce_n;
    logic ram_oe_n;
    logic external_fetch_select;
  } mmld_mem_sel_t;

  // High address byte falls inside the given lamp page
  function automatic logic mmld_page_hit(input logic [7:0] addr, input logic [7:0] page);
    mmld_page_hit = (addr & LAMP_DECODE_MASK) == page;
  endfunction

  // Off page of lamp n
  function automatic logic [7:0] mmld_off_page(input int n);
    mmld_off_page = LAMP_BASE_PAGE + LAMP_PAGE_STEP * 8'(n);
  endfunction

endpackage

`default_nettype wire

/* tb/mmld_core_model.sv */
// Behavioural core model driving the high address byte, strobes and clock output
`timescale 1ns/1ns
`default_nettype none

module mmld_core_model
  import mmld_pkg::*;
(
  // Clock
  input  wire logic      i_ref_clk,
  // Map strap state as the core sees it
  input  wire logic      i_flash_map,
  // Core bus and clock output
  output var  mmld_bus_t o_bus,
  output var  logic      o_core_clock_output
);
  // Idle bus at time zero, clock output stopped low
  initial begin
    o_bus               = {8'h00, 1'b1, 1'b1};
    o_core_clock_output = 1'b0;
  end

  // One bus cycle: address and strobes, optional clock tick, then release
  task automatic access(input logic [7:0] page, input logic rd_n, input logic psen_n,
                        input logic tick);
    logic hide;
    hide = (page < 8'h40);
    @(posedge i_ref_clk);
    // Flash map: internal RAM is data only, so low fetches go out
    o_bus               <= {page, rd_n | hide, psen_n | (hide & ~i_flash_map)};
    o_core_clock_output <= 1'b0;
    @(posedge i_ref_clk);
    o_core_clock_output <= tick;
    @(posedge i_ref_clk);
    o_bus               <= {~page, 1'b1, 1'b1};  // Released lines show the inverse
    o_core_clock_output <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the memory map and lamp decoder
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench
  import mmld_pkg::*;
;
  logic          i_ref_clk = 1'b0;
  logic          i_rstn;
  logic          strap_high;
  logic          strap_low;
  mmld_bus_t     bus;
  logic          core_clk;
  mmld_mem_sel_t mem_sel;
  wire  [3:0]    lamps;
  int            bad_count;
  int            compares;

  // Clock at 25 MHz
  always #20 i_ref_clk = ~i_ref_clk;

  mmld_decoder dut (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_map_strap_high(strap_high),
    .i_map_strap_low(strap_low), .i_bus(bus), .i_core_clock_output(core_clk),
    .o_mem_sel(mem_sel), .o_lamp_one(lamps[0]), .o_lamp_two(lamps[1]),
    .o_lamp_three(lamps[2]), .o_lamp_four(lamps[3])
  );

  mmld_core_model core (.i_ref_clk(i_ref_clk), .i_flash_map(strap_high & ~strap_low),
                        .o_bus(bus), .o_core_clock_output(core_clk));

  // Expected {ram_ce_n, ram_oe_n, external_fetch_select} for a map and access
  function automatic logic [2:0] exp_sel(input logic [1:0] m, input logic [7:0] pg,
                                         input logic rd_n, input logic psen_n);
    case (m)
      2'h0:    exp_sel = 3'h6;
      2'h1:    exp_sel = {~pg[7], rd_n & psen_n, 1'b0};
      2'h3:    exp_sel = {1'b0, rd_n & psen_n, 1'b0};
      default: exp_sel = {1'b0, rd_n & psen_n, 1'b1};
    endcase
  endfunction

  // Every map against reads, fetches and idle cycles, low and high pages
  task automatic map_test();
    logic [7:0] pages[4] = '{8'h20, 8'h48, 8'h90, 8'hC8};
    logic [1:0] strb[3]  = '{2'h1, 2'h2, 2'h3};
    logic       hide;
    logic       rd_eff;
    logic       psen_eff;
    for (int m = 0; m < 4; m++) begin
      @(posedge i_ref_clk);
      {strap_high, strap_low} <= 2'(m);
      for (int p = 0; p < 4; p++) begin
        hide = (pages[p] < 8'h40);
        for (int s = 0; s < 3; s++) begin
          core.access(pages[p], strb[s][1], strb[s][0], 1'b0);
          #1;
          // Strobes as the core really drives them in the lowest block
          rd_eff   = strb[s][1] | hide;
          psen_eff = strb[s][0] | (hide & (m != 2));
          `CHK(mem_sel, exp_sel(2'(m), pages[p], rd_eff, psen_eff))
        end
      end
    end
    $display("test map_test done");
  endtask

  // Lamps set by on-page reads, untouched by fetches and missing ticks
  task automatic lamp_test();
    logic [7:0] off;
    logic [3:0] lv;
    lv = 4'h0;
    for (int n = 0; n < 4; n++) begin
      off = 8'h80 + 8'(n * 16);
      core.access(off | 8'h0B, 1'b0, 1'b1, 1'b1);
      #1;
      lv[n] = 1'b1;
      `CHK(lamps, lv)
      core.access(off | 8'h03, 1'b1, 1'b0, 1'b1);
      #1;
      `CHK(lamps, lv)
    end
    for (int n = 0; n < 4; n++) begin
      off = 8'h80 + 8'(n * 16);
      core.access(off, 1'b0, 1'b1, 1'b0);
      #1;
      `CHK(lamps, lv)
      core.access(off | 8'h05, 1'b0, 1'b1, 1'b1);
      #1;
      lv[n] = 1'b0;
      `CHK(lamps, lv)
    end
    $display("test lamp_test done");
  endtask

  // Counts and verdict, then end of run
  task automatic stop_test();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    i_rstn     = 1'b0;
    strap_high = 1'b1;
    strap_low  = 1'b1;
    bad_count  = 0;
    compares   = 0;
    repeat (12) @(posedge i_ref_clk);
    #1;
    `CHK(mem_sel, 3'h6)
    `CHK(lamps, 4'h0)
    @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    $display("test reset_test done");
    map_test();
    lamp_test();
    stop_test();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #100_000;
    bad_count++;
    $display("Watchdog expired");
    stop_test();
  end
endmodule

`default_nettype wire
